// [pkg/uctl_pkg.sv]
// Purpose: Shared constants and types of the serial port control block
// Assumes: Avalon-MM byte addresses, 32-bit data
// Notes: Each register takes one aligned word
package uctl_pkg;
  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0] OFS_DATA = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h18;
  localparam logic [7:0] OFS_INT_DIV = 8'h24;
  localparam logic [7:0] OFS_FRAC_DIV = 8'h28;
  localparam logic [7:0] OFS_CTRL = 8'h30;
  // ****************************************
  // Field positions
  // ****************************************
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_OVS_BIT = 3;
  localparam int CTRL_TXE_BIT = 8;
  localparam int CTRL_RXE_BIT = 9;
  localparam int CTRL_RTS_BIT = 11;
  localparam int CTRL_RTSFLOW_BIT = 14;
  localparam int CTRL_CTSFLOW_BIT = 15;
  localparam int CTRL_DLY_LSB = 16;
  localparam int CTRL_DLY_MSB = 19;
  localparam int STAT_TX_BUSY_BIT = 0;
  localparam int STAT_TX_FULL_BIT = 1;
  localparam int STAT_RX_FULL_BIT = 2;
  localparam int STAT_RX_BUSY_BIT = 3;
  localparam int STAT_CTS_BIT = 4;
  // ****************************************
  // Reset values and counts
  // ****************************************
  localparam logic EN_RESET = 1'b0;
  localparam logic TXE_RESET = 1'b1;
  localparam logic RXE_RESET = 1'b1;
  localparam logic [3:0] DLY_RESET = 4'h4;
  localparam logic [15:0] INT_DIV_RESET = 16'h0001;
  localparam logic [5:0] FRAC_DIV_RESET = 6'h00;
  localparam logic [3:0] LAST_TICK_WIDE = 4'hF;
  localparam logic [3:0] LAST_TICK_NARROW = 4'h7;
  localparam logic [3:0] HALF_TICK_WIDE = 4'h7;
  localparam logic [3:0] HALF_TICK_NARROW = 4'h3;
  localparam logic [2:0] LAST_DATA_BIT = 3'h7;
  // ****************************************
  // Types
  // ****************************************
  typedef struct packed {
    logic [3:0] sample_delay;
    logic cts_flow;
    logic rts_flow;
    logic rts;
    logic receive_enable_bit;
    logic transmit_enable_bit;
    logic ovs;
    logic en;
  } uctl_ctrl_t;

  typedef struct packed {
    logic read;
    logic write;
    logic [7:0] address;
    logic [31:0] writedata;
  } uctl_av_req_t;

  typedef enum logic [3:0] {
    TX_IDLE = 4'h1,
    TX_START = 4'h2,
    TX_DATA = 4'h4,
    TX_STOP = 4'h8
  } uctl_tx_state_t;

  typedef enum logic [3:0] {
    RX_IDLE = 4'h1,
    RX_START = 4'h2,
    RX_DATA = 4'h4,
    RX_STOP = 4'h8
  } uctl_rx_state_t;
endpackage : uctl_pkg

// [verilog/uctl_baud.sv]
// Purpose: Oversampling tick from integer and fractional divisor
// Assumes: Divisor held stable by the caller while a character is running
// Notes: Fraction is in 64ths of a reference cycle
`timescale 1ns/1ps
module uctl_baud import uctl_pkg::*; (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Divisor
  input wire logic [15:0] int_div,
  input wire logic [5:0] frac_div,
  // Tick
  output logic tick
);
  typedef struct packed {
    logic [15:0] cnt;
    logic [5:0] acc;
    logic extra;
    logic tick;
  } uctl_baud_st_t;

  uctl_baud_st_t st;
  uctl_baud_st_t nx;
  logic [15:0] limit;
  logic [6:0] sum;

  always_comb begin
    nx = st;
    nx.tick = 1'b0;
    // Zero divisor behaves as one, avoids a stuck counter
    limit = (int_div == 16'h0000) ? 16'h0000 : 16'(int_div - 16'h0001);
    limit = 16'(limit + {15'h0000, st.extra});
    sum = {1'b0, st.acc} + {1'b0, frac_div};
    if (st.cnt >= limit) begin
      nx.cnt = 16'h0000;
      nx.tick = 1'b1;
      nx.acc = sum[5:0];
      nx.extra = sum[6];
    end else begin
      nx.cnt = 16'(st.cnt + 16'h0001);
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      st <= '0;
    end else begin
      st <= nx;
    end
  end

  assign tick = st.tick;
endmodule : uctl_baud

// [verilog/uctl_top.sv]
// Purpose: Serial port control register and character engine
// Assumes: clk is the reference clock; 8 data bits, no parity, 1 stop
// Notes: One-character holding registers each way
//
// What this block does
// [RL1] Control bit 0 enables the port; cleared means no transmit or receive.
// [RL2] Clearing the enable mid-character lets that character finish first.
// [RL3] Bit 3 selects 16 or 8 divisor ticks per bit period.
// [RL4] Supports clock/16 baud wide and clock/8 baud narrow oversampling.
// [RL5] Transmit enable bit 8 resets to 1 and gates the transmitter.
// [RL6] Receive enable bit 9 resets to 1 and gates the receiver.
// [RL7] Bit 11 drives the request-to-send pin inverted.
// [RL8] With bit 14 set, request data only while receive space exists.
// [RL9] With bit 15 set, start sending only while clear-to-send is asserted.
// [RL10] Bits 19:16, reset 4, set start-bit wait in reference cycles.
// [RL11] Software uses the start-bit field only at divisor 1, eightfold.
// [RL12] Software sets the field to clock over twice baud, minus one.
// [RL13] Divisor has integer and fraction; changes apply after the character.
`timescale 1ns/1ps
module uctl_top import uctl_pkg::*; (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Avalon-MM slave
  input wire uctl_av_req_t av_req,
  output logic [31:0] av_readdata,
  output logic av_waitrequest,
  // Serial lines
  input wire logic rx_pin,
  input wire logic cts_b,
  output logic tx_pin,
  output logic rts_b
);
  typedef struct packed {
    uctl_ctrl_t ctrl;
    logic [15:0] sw_int_div;
    logic [5:0] sw_frac_div;
    logic [15:0] div_int;
    logic [5:0] div_frac;
    logic waitreq;
    logic [31:0] rdata;
    logic rx_m;
    logic rx_s;
    logic cts_m;
    logic cts_s;
    uctl_tx_state_t tx_state;
    logic [3:0] tx_tcnt;
    logic [2:0] tx_bit;
    logic [7:0] tx_shift;
    logic [7:0] tx_hold;
    logic tx_full;
    logic tx_line;
    uctl_rx_state_t rx_state;
    logic [3:0] rx_tcnt;
    logic [2:0] rx_bit;
    logic [7:0] rx_shift;
    logic [7:0] rx_hold;
    logic rx_full;
    logic rts_line;
  } uctl_top_st_t;

  uctl_top_st_t st;
  uctl_top_st_t nx;
  logic tick;
  logic do_wr;
  logic do_rd;
  logic cts_ok;
  logic fast_start;

  function automatic logic bit_end(input logic [3:0] cnt, input logic ovs);
    bit_end = (cnt == (ovs ? LAST_TICK_NARROW : LAST_TICK_WIDE)); // [RL3]
  endfunction : bit_end

  // ****************************************
  // Tick generator
  // ****************************************
  uctl_baud u_baud (
    .clk(clk),
    .rst_b(rst_b),
    .int_div(st.div_int),
    .frac_div(st.div_frac),
    .tick(tick)
  );

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    nx = st;
    do_wr = av_req.write & ~st.waitreq;
    do_rd = av_req.read & ~st.waitreq;
    // One wait cycle per access, then ready for one edge
    nx.waitreq = ~((av_req.read | av_req.write) & st.waitreq);
    nx.rdata = 32'h0000_0000;
    unique case (av_req.address)
      OFS_DATA: nx.rdata[7:0] = st.rx_hold;
      OFS_STATUS: begin
        nx.rdata[STAT_TX_BUSY_BIT] = (st.tx_state != TX_IDLE);
        nx.rdata[STAT_TX_FULL_BIT] = st.tx_full;
        nx.rdata[STAT_RX_FULL_BIT] = st.rx_full;
        nx.rdata[STAT_RX_BUSY_BIT] = (st.rx_state != RX_IDLE);
        nx.rdata[STAT_CTS_BIT] = ~st.cts_s;
      end
      OFS_INT_DIV: nx.rdata[15:0] = st.sw_int_div;
      OFS_FRAC_DIV: nx.rdata[5:0] = st.sw_frac_div;
      OFS_CTRL: begin
        nx.rdata[CTRL_EN_BIT] = st.ctrl.en;
        nx.rdata[CTRL_OVS_BIT] = st.ctrl.ovs;
        nx.rdata[CTRL_TXE_BIT] = st.ctrl.transmit_enable_bit;
        nx.rdata[CTRL_RXE_BIT] = st.ctrl.receive_enable_bit;
        nx.rdata[CTRL_RTS_BIT] = st.ctrl.rts;
        nx.rdata[CTRL_RTSFLOW_BIT] = st.ctrl.rts_flow;
        nx.rdata[CTRL_CTSFLOW_BIT] = st.ctrl.cts_flow;
        nx.rdata[CTRL_DLY_MSB:CTRL_DLY_LSB] = st.ctrl.sample_delay;
      end
      default: nx.rdata = 32'h0000_0000;
    endcase
    // Pin synchronisers
    nx.rx_m = rx_pin;
    nx.rx_s = st.rx_m;
    nx.cts_m = cts_b;
    nx.cts_s = st.cts_m;
    cts_ok = ~st.ctrl.cts_flow | ~st.cts_s; // [RL9]
    if (do_rd && av_req.address == OFS_DATA) begin
      nx.rx_full = 1'b0;
    end
    if (do_wr) begin
      unique case (av_req.address)
        OFS_DATA: begin
          // Byte written while holding is full is dropped
          if (!st.tx_full) begin
            nx.tx_hold = av_req.writedata[7:0];
            nx.tx_full = 1'b1;
          end
        end
        OFS_INT_DIV: nx.sw_int_div = av_req.writedata[15:0];
        OFS_FRAC_DIV: nx.sw_frac_div = av_req.writedata[5:0];
        OFS_CTRL: begin
          nx.ctrl.en = av_req.writedata[CTRL_EN_BIT]; // [RL1]
          nx.ctrl.ovs = av_req.writedata[CTRL_OVS_BIT]; // [RL3]
          nx.ctrl.transmit_enable_bit = av_req.writedata[CTRL_TXE_BIT]; // [RL5]
          nx.ctrl.receive_enable_bit = av_req.writedata[CTRL_RXE_BIT]; // [RL6]
          nx.ctrl.rts = av_req.writedata[CTRL_RTS_BIT];
          nx.ctrl.rts_flow = av_req.writedata[CTRL_RTSFLOW_BIT];
          nx.ctrl.cts_flow = av_req.writedata[CTRL_CTSFLOW_BIT];
          nx.ctrl.sample_delay = av_req.writedata[CTRL_DLY_MSB:CTRL_DLY_LSB]; // [RL10]
        end
        default: nx.ctrl = st.ctrl;
      endcase
    end
    // Divisor only follows software between characters
    if (st.tx_state == TX_IDLE && st.rx_state == RX_IDLE) begin
      nx.div_int = st.sw_int_div; // [RL13]
      nx.div_frac = st.sw_frac_div; // [RL13]
    end
    // Transmitter; enables are looked at only when idle
    unique case (st.tx_state)
      TX_IDLE: begin
        nx.tx_tcnt = 4'h0;
        if (st.tx_full && st.ctrl.en && st.ctrl.transmit_enable_bit && cts_ok) begin // [RL1] [RL5] [RL9]
          nx.tx_shift = st.tx_hold;
          nx.tx_full = 1'b0;
          nx.tx_line = 1'b0;
          nx.tx_state = TX_START;
        end
      end
      default: begin
        if (tick) begin
          nx.tx_tcnt = 4'(st.tx_tcnt + 4'h1);
          if (bit_end(st.tx_tcnt, st.ctrl.ovs)) begin // [RL2] [RL4]
            nx.tx_tcnt = 4'h0;
            if (st.tx_state == TX_START) begin
              nx.tx_line = st.tx_shift[0];
              nx.tx_bit = 3'h0;
              nx.tx_state = TX_DATA;
            end else if (st.tx_state == TX_DATA) begin
              if (st.tx_bit == LAST_DATA_BIT) begin
                nx.tx_line = 1'b1;
                nx.tx_state = TX_STOP;
              end else begin
                nx.tx_line = st.tx_shift[1];
                nx.tx_shift = {1'b0, st.tx_shift[7:1]};
                nx.tx_bit = 3'(st.tx_bit + 3'h1);
              end
            end else begin
              nx.tx_state = TX_IDLE;
            end
          end
        end
      end
    endcase
    // Receiver; fast start wait counts reference cycles, else ticks
    fast_start = (st.div_int == INT_DIV_RESET) && st.ctrl.ovs;
    unique case (st.rx_state)
      RX_IDLE: begin
        nx.rx_tcnt = 4'h0;
        if (!st.rx_s && st.ctrl.en && st.ctrl.receive_enable_bit) begin // [RL1] [RL6]
          nx.rx_state = RX_START;
        end
      end
      RX_START: begin
        if (fast_start || tick) begin
          nx.rx_tcnt = 4'(st.rx_tcnt + 4'h1);
        end
        if ((fast_start && st.rx_tcnt == st.ctrl.sample_delay) || // [RL10]
            (!fast_start && tick && st.rx_tcnt == (st.ctrl.ovs ? HALF_TICK_NARROW : HALF_TICK_WIDE))) begin
          nx.rx_tcnt = 4'h0;
          nx.rx_bit = 3'h0;
          // Glitch shorter than half a bit is not a start
          nx.rx_state = st.rx_s ? RX_IDLE : RX_DATA;
        end
      end
      default: begin
        if (tick) begin
          nx.rx_tcnt = 4'(st.rx_tcnt + 4'h1);
          if (bit_end(st.rx_tcnt, st.ctrl.ovs)) begin // [RL2] [RL4]
            nx.rx_tcnt = 4'h0;
            if (st.rx_state == RX_DATA) begin
              nx.rx_shift = {st.rx_s, st.rx_shift[7:1]};
              nx.rx_bit = 3'(st.rx_bit + 3'h1);
              if (st.rx_bit == LAST_DATA_BIT) begin
                nx.rx_state = RX_STOP;
              end
            end else begin
              // Overrun and framing errors drop the byte
              if (st.rx_s && !st.rx_full) begin
                nx.rx_hold = st.rx_shift;
                nx.rx_full = 1'b1;
              end
              nx.rx_state = RX_IDLE;
            end
          end
        end
      end
    endcase
    nx.rts_line = st.ctrl.rts_flow ? st.rx_full : ~st.ctrl.rts; // [RL7] [RL8]
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      st <= '0;
      st.ctrl.en <= EN_RESET;
      st.ctrl.transmit_enable_bit <= TXE_RESET; // [RL5]
      st.ctrl.receive_enable_bit <= RXE_RESET; // [RL6]
      st.ctrl.sample_delay <= DLY_RESET; // [RL10]
      st.sw_int_div <= INT_DIV_RESET;
      st.sw_frac_div <= FRAC_DIV_RESET;
      st.div_int <= INT_DIV_RESET;
      st.div_frac <= FRAC_DIV_RESET;
      st.waitreq <= 1'b1;
      st.rx_m <= 1'b1;
      st.rx_s <= 1'b1;
      st.cts_m <= 1'b1;
      st.cts_s <= 1'b1;
      st.tx_state <= TX_IDLE;
      st.rx_state <= RX_IDLE;
      st.tx_line <= 1'b1;
      st.rts_line <= 1'b1;
    end else begin
      st <= nx;
    end
  end

  assign av_readdata = st.rdata;
  assign av_waitrequest = st.waitreq;
  assign tx_pin = st.tx_line;
  assign rts_b = st.rts_line;

  // ****************************************
  // Checks
  // ****************************************
  property p_tx_off;
    @(posedge clk) disable iff (!rst_b) (st.tx_state == TX_IDLE && !st.ctrl.en) |=> st.tx_state == TX_IDLE;
  endproperty
  a_tx_off: assert property (p_tx_off) else $error("transmitter started while port disabled"); // [RL1]

  property p_finish;
    @(posedge clk) disable iff (!rst_b) (st.tx_state == TX_DATA && !st.ctrl.en) |=> st.tx_state != TX_IDLE;
  endproperty
  a_finish: assert property (p_finish) else $error("character cut short"); // [RL2]

  property p_ovs;
    @(posedge clk) disable iff (!rst_b) st.ctrl.ovs |-> st.tx_tcnt <= LAST_TICK_NARROW;
  endproperty
  a_ovs: assert property (p_ovs) else $error("bit period too long in eightfold mode"); // [RL3]

  property p_txe_reset;
    @(posedge clk) (!$past(rst_b) && rst_b) |-> (st.ctrl.transmit_enable_bit && st.ctrl.receive_enable_bit && st.ctrl.sample_delay == DLY_RESET);
  endproperty
  a_txe_reset: assert property (p_txe_reset) else $error("wrong control reset value"); // [RL5]

  property p_rxe_gate;
    @(posedge clk) disable iff (!rst_b) (st.rx_state == RX_IDLE && !st.ctrl.receive_enable_bit) |=> st.rx_state == RX_IDLE;
  endproperty
  a_rxe_gate: assert property (p_rxe_gate) else $error("receiver started while disabled"); // [RL6]

  property p_rts_pol;
    @(posedge clk) disable iff (!rst_b) !st.ctrl.rts_flow |=> rts_b == !$past(st.ctrl.rts);
  endproperty
  a_rts_pol: assert property (p_rts_pol) else $error("request-to-send polarity wrong"); // [RL7]

  property p_rts_flow;
    @(posedge clk) disable iff (!rst_b) (st.ctrl.rts_flow && st.rx_full) |=> rts_b;
  endproperty
  a_rts_flow: assert property (p_rts_flow) else $error("data requested with no space"); // [RL8]

  property p_cts;
    @(posedge clk) disable iff (!rst_b) (st.tx_state == TX_IDLE && st.ctrl.cts_flow && st.cts_s) |=> st.tx_state == TX_IDLE;
  endproperty
  a_cts: assert property (p_cts) else $error("send started without clear-to-send"); // [RL9]

  property p_div;
    @(posedge clk) disable iff (!rst_b) !$stable(st.div_int) |-> $past(st.tx_state == TX_IDLE && st.rx_state == RX_IDLE);
  endproperty
  a_div: assert property (p_div) else $error("divisor changed mid character"); // [RL13]
endmodule : uctl_top

// [tb/uctl_peer.sv]
// Purpose: Remote serial peer with clear-to-send control
// Assumes: 8 data bits, no parity, one stop bit
// Notes: Bit period given in reference cycles by the bench
`timescale 1ns/1ps
module uctl_peer (
  // Clock
  input wire logic clk,
  // Setup
  input wire logic [7:0] bit_cyc,
  input wire logic hold_cts,
  // Serial lines
  input wire logic tx_pin,
  output logic rx_pin,
  output logic cts_b,
  // Received character
  output logic [7:0] got_byte,
  output logic got_valid
);
  initial begin
    rx_pin = 1'b1;
    got_byte = 8'h00;
    got_valid = 1'b0;
  end
  // High blocks the port from starting a character
  assign cts_b = hold_cts;
  // ****************************************
  // Receiver, samples mid-bit
  // ****************************************
  always begin
    @(negedge tx_pin);
    repeat (bit_cyc / 2) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      repeat (bit_cyc) @(posedge clk);
      got_byte[i] <= tx_pin;
    end
    repeat (bit_cyc) @(posedge clk);
    // A low stop bit drops the character, so it shows as missing
    got_valid <= tx_pin;
    @(posedge clk);
    got_valid <= 1'b0;
  end
  // ****************************************
  // Transmitter, LSB first
  // ****************************************
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge clk);
      rx_pin <= f[i];
      repeat (bit_cyc - 1) @(posedge clk);
    end
  endtask : send
endmodule : uctl_peer

// [tb/tb_uctl_top.sv]
// Purpose: Self-checking bench of the serial port control block
// Assumes: Peer runs at the bit period the bench programs
// Notes: Reads and peer characters are checked from queues
`timescale 1ns/1ps
module tb_uctl_top import uctl_pkg::*;;
  logic clk = 1'b0;
  logic rst_b;
  uctl_av_req_t av_req;
  logic [31:0] av_readdata;
  logic av_waitrequest;
  logic rx_pin, cts_b, tx_pin, rts_b, hold_cts, got_valid;
  logic [7:0] peer_cyc, got_byte, b;
  logic [31:0] rd_q[$];
  logic [7:0] tx_q[$];
  logic [31:0] lfsr_st;
  int n_errors, cmp_count;
  always #20 clk = ~clk;
  uctl_top u_uctl_top (.clk(clk), .rst_b(rst_b), .av_req(av_req), .av_readdata(av_readdata),
    .av_waitrequest(av_waitrequest), .rx_pin(rx_pin), .cts_b(cts_b), .tx_pin(tx_pin), .rts_b(rts_b));
  uctl_peer u_uctl_peer (.clk(clk), .bit_cyc(peer_cyc), .hold_cts(hold_cts), .tx_pin(tx_pin),
    .rx_pin(rx_pin), .cts_b(cts_b), .got_byte(got_byte), .got_valid(got_valid));
  // ****************************************
  // Helpers
  // ****************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic final_report();
    if (n_errors == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : final_report
  function automatic logic [31:0] cw(input logic en, ovs, transmit_enable_bit, receive_enable_bit, rts, rf, cf, input logic [3:0] d);
    cw = 32'h0;
    cw[CTRL_EN_BIT] = en;
    cw[CTRL_OVS_BIT] = ovs;
    cw[CTRL_TXE_BIT] = transmit_enable_bit;
    cw[CTRL_RXE_BIT] = receive_enable_bit;
    cw[CTRL_RTS_BIT] = rts;
    cw[CTRL_RTSFLOW_BIT] = rf;
    cw[CTRL_CTSFLOW_BIT] = cf;
    cw[CTRL_DLY_MSB:CTRL_DLY_LSB] = d;
  endfunction : cw
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    lfsr_next = {s[30:0], 1'b0} ^ (s[31] ? 32'h04C11DB7 : 32'h00000000);
  endfunction : lfsr_next
  task automatic rnd(output logic [7:0] v);
    lfsr_st = lfsr_next(lfsr_st);
    v = lfsr_st[7:0];
  endtask : rnd
  // Holds the request until waitrequest is sampled low
  // Only the watchdog ends a wait that never gets an answer
  task automatic av_cycle(input logic wr, input logic [7:0] addr, input logic [31:0] data);
    @(posedge clk);
    av_req <= '{read: !wr, write: wr, address: addr, writedata: data};
    @(posedge clk);
    while (av_waitrequest !== 1'b0) begin
      @(posedge clk);
    end
    av_req <= '0;
  endtask : av_cycle
  task automatic av_wr(input logic [7:0] addr, input logic [31:0] data);
    av_cycle(1'b1, addr, data);
  endtask : av_wr
  task automatic av_rd(input logic [7:0] addr, input logic [31:0] exp);
    rd_q.push_back(exp);
    av_cycle(1'b0, addr, 32'h00000000);
  endtask : av_rd
  task automatic tx_send(input logic [7:0] v);
    tx_q.push_back(v);
    av_wr(OFS_DATA, {24'h000000, v});
  endtask : tx_send
  task automatic quiet(input int n);
    repeat (n) begin
      @(posedge clk);
      check(tx_pin, 1'b1);
    end
  endtask : quiet
  task automatic wait_tx();
    int n;
    n = 0;
    while (tx_q.size() != 0 && n < 4000) begin
      @(posedge clk);
      n++;
    end
    repeat (2 * peer_cyc) @(posedge clk);
    check(tx_q.size(), 32'h0);
  endtask : wait_tx
  // ****************************************
  // Scoreboard
  // ****************************************
  always @(posedge clk) begin
    if (av_req.read && av_waitrequest === 1'b0) begin
      check(av_readdata, rd_q.pop_front());
    end
    if (got_valid === 1'b1) begin
      if (tx_q.size() == 0) check(32'h1, 32'h0);
      else check({24'h0, got_byte}, {24'h0, tx_q.pop_front()});
    end
  end
  initial begin
    repeat (40000) @(posedge clk);
    n_errors++;
    final_report();
  end
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    rst_b = 1'b0;
    av_req = '0;
    peer_cyc = 8'h10;
    hold_cts = 1'b0;
    n_errors = 0;
    cmp_count = 0;
    lfsr_st = 32'h85F136E1;
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    av_rd(OFS_CTRL, 32'h00040300);
    av_rd(8'h3C, 32'h00000000);
    check(rts_b, 1'b1);
    av_wr(OFS_CTRL, cw(0, 0, 1, 1, 1, 0, 0, 4'h4));
    repeat (3) @(posedge clk);
    check(rts_b, 1'b0);
    rnd(b);
    tx_send(b);
    quiet(200);
    av_wr(OFS_CTRL, cw(1, 0, 1, 1, 0, 0, 0, 4'h4));
    wait_tx();
    check(rts_b, 1'b1);
    peer_cyc <= 8'h08;
    av_wr(OFS_CTRL, cw(1, 1, 0, 1, 0, 0, 0, 4'h4));
    rnd(b);
    tx_send(b);
    quiet(150);
    av_wr(OFS_CTRL, cw(1, 1, 1, 1, 0, 0, 0, 4'h4));
    wait_tx();
    hold_cts <= 1'b1;
    av_wr(OFS_CTRL, cw(1, 1, 1, 1, 0, 0, 1, 4'h4));
    repeat (4) @(posedge clk);
    rnd(b);
    tx_send(b);
    quiet(150);
    hold_cts <= 1'b0;
    wait_tx();
    // Clearing the enable mid-character must not truncate it
    rnd(b);
    tx_send(b);
    repeat (30) @(posedge clk);
    av_wr(OFS_CTRL, cw(0, 1, 1, 1, 0, 0, 0, 4'h4));
    wait_tx();
    rnd(b);
    tx_send(b);
    quiet(100);
    av_wr(OFS_CTRL, cw(1, 1, 1, 1, 0, 0, 0, 4'h4));
    wait_tx();
    // New divisor only after the running character
    rnd(b);
    tx_send(b);
    repeat (20) @(posedge clk);
    av_wr(OFS_INT_DIV, 32'h00000002);
    wait_tx();
    peer_cyc <= 8'h10;
    rnd(b);
    tx_send(b);
    wait_tx();
    av_wr(OFS_INT_DIV, 32'h00000001);
    peer_cyc <= 8'h08;
    // 25 MHz over twice 3.125 Mbaud, minus one
    av_wr(OFS_CTRL, cw(1, 1, 1, 1, 0, 1, 0, 4'h3));
    repeat (3) @(posedge clk);
    check(rts_b, 1'b0);
    rnd(b);
    u_uctl_peer.send(b);
    repeat (8) @(posedge clk);
    check(rts_b, 1'b1);
    av_rd(OFS_STATUS, 32'h00000014);
    av_rd(OFS_DATA, {24'h000000, b});
    repeat (3) @(posedge clk);
    check(rts_b, 1'b0);
    av_wr(OFS_CTRL, cw(1, 1, 1, 0, 0, 0, 0, 4'h3));
    rnd(b);
    u_uctl_peer.send(b);
    repeat (8) @(posedge clk);
    av_rd(OFS_STATUS, 32'h00000010);
    // Divisor 2 leaves the fast start path, half-bit wait in ticks
    av_wr(OFS_INT_DIV, 32'h00000002);
    av_wr(OFS_CTRL, cw(1, 1, 1, 1, 0, 0, 0, 4'h3));
    peer_cyc <= 8'h10;
    rnd(b);
    u_uctl_peer.send(b);
    repeat (8) @(posedge clk);
    av_rd(OFS_DATA, {24'h000000, b});
    // Fraction field keeps only its six bits
    av_wr(OFS_FRAC_DIV, 32'h000000FF);
    av_rd(OFS_FRAC_DIV, 32'h0000003F);
    av_rd(OFS_INT_DIV, 32'h00000002);
    repeat (4) @(posedge clk);
    check(rd_q.size(), 32'h0);
    final_report();
  end
endmodule : tb_uctl_top
